// ---- rri_pkg.sv ----
`default_nettype none
package rri_pkg;

	// register byte offsets on the apb bus
	localparam logic [7:0] REG_RSC = 8'h00;
	localparam logic [7:0] REG_SPTR = 8'h04;
	localparam logic [7:0] REG_TOS = 8'h08;
	localparam logic [7:0] REG_PC = 8'h0C;
	localparam logic [7:0] REG_INTCON = 8'h10;
	localparam logic [7:0] REG_PIR1 = 8'h14;
	localparam logic [7:0] REG_PA_LAT = 8'h18;
	localparam logic [7:0] REG_PA_DIR = 8'h1C;
	localparam logic [7:0] REG_PA_PINS = 8'h20;

	// widths and depths
	localparam int PC_W = 21;
	localparam int STK_AW = 5;
	localparam int STK_DEPTH = 32;
	localparam int SYNC_W = 11;
	localparam logic [STK_AW-1:0] STK_PTR_MAX = 5'h1F;
	localparam logic [STK_AW-1:0] STK_PTR_EMPTY = 5'h00;

	// program counter values
	localparam logic [PC_W-1:0] PC_RESET = 21'h0_0000;
	localparam logic [PC_W-1:0] PC_STEP = 21'h0_0002;
	localparam logic [PC_W-1:0] VEC_HIGH = 21'h0_0008;
	localparam logic [PC_W-1:0] VEC_LOW = 21'h0_0018;

	// reset status register: keep mask and forced value per event class
	localparam logic [7:0] RSC_IMPL = 8'hDF;
	localparam logic [7:0] RSC_WMASK = 8'hD3;
	localparam logic [7:0] RSC_POR_KEEP = 8'h00;
	localparam logic [7:0] RSC_POR_VAL = 8'h1C;
	localparam logic [7:0] RSC_BOR_KEEP = 8'h42;
	localparam logic [7:0] RSC_BOR_VAL = 8'h1C;
	localparam logic [7:0] RSC_PIN_KEEP = 8'h1F;
	localparam logic [7:0] RSC_PIN_SLP_KEEP = 8'h13;
	localparam logic [7:0] RSC_PIN_SLP_VAL = 8'h08;
	localparam logic [7:0] RSC_INSTR_KEEP = 8'h4F;
	localparam logic [7:0] RSC_STK_KEEP = 8'h5F;
	localparam logic [7:0] RSC_WDT_KEEP = 8'h53;
	localparam logic [7:0] RSC_WDT_VAL = 8'h04;
	localparam logic [7:0] RSC_WAKE_KEEP = 8'hD3;
	localparam logic [7:0] RSC_WDT_WAKE_VAL = 8'h00;
	localparam logic [7:0] RSC_INT_WAKE_VAL = 8'h08;
	localparam logic [7:0] RSC_ZERO = 8'h00;

	// other register reset values and masks
	localparam logic [7:0] SPTR_IMPL = 8'hDF;
	localparam logic [7:0] SPTR_RST = 8'h00;
	localparam logic [7:0] INTCON_RST = 8'h00;
	localparam logic [7:0] INTCON_RST_KEEP = 8'h01;
	localparam logic [7:0] PIR1_RST = 8'h00;
	localparam logic [7:0] PA_LAT_POR = 8'h00;
	localparam logic [7:0] PA_DIR_RST = 8'h7F;
	localparam logic [7:0] PA_MASK_FULL = 8'h7F;
	localparam logic [7:0] PA_MASK_GATED = 8'h3F;

	// oscillator mode codes that free the port a bit 6 pin
	localparam logic [2:0] OSC_EXT_CLOCK_IO = 3'h5;
	localparam logic [2:0] OSC_RC_IO = 3'h7;

	typedef enum logic [3:0] {
		CLS_POR, CLS_BOR, CLS_PIN, CLS_PIN_SLEEP, CLS_WDT, CLS_INSTR,
		CLS_STK_FULL, CLS_STK_UNF, CLS_WDT_WAKE, CLS_INT_WAKE
	} rri_class_e;

	typedef enum logic [1:0] {ST_RUN, ST_HOLD, ST_INIT} rri_state_e;

	typedef struct packed {
		logic int_prio_en;
		logic long_write_en;
		logic rsvd;
		logic reset_instr_n;
		logic timeout_n;
		logic power_down_n;
		logic power_on_n;
		logic brown_out_n;
	} rri_rsc_s;

	typedef struct packed {
		logic full;
		logic underflow;
		logic rsvd;
		logic [STK_AW-1:0] ptr;
	} rri_sptr_s;

	typedef struct packed {
		logic wdt_timeout;
		logic reset_instr;
		logic stack_full;
		logic stack_underflow;
	} rri_core_evt_s;

	typedef struct packed {
		logic high_prio;
		logic [2:0] intcon_flags;
		logic [7:0] pir_flags;
	} rri_wake_s;

endpackage
`default_nettype wire

// ---- rri_sync.sv ----
`timescale 1ns/10ps
`default_nettype none

module rri_sync (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// asynchronous levels in, synchronised levels out
	input wire logic [rri_pkg::SYNC_W-1:0] i_d,
	output logic [rri_pkg::SYNC_W-1:0] o_q
);
	import rri_pkg::*;

	genvar g;
	generate
		for (g = 0; g < SYNC_W; g++) begin : g_bit
			logic meta;
			logic next_meta;
			logic next_q;
			always_comb begin
				next_meta = i_d[g];
				next_q = meta;
			end
			always_ff @(posedge i_clk) begin
				if (i_rst) begin
					meta <= 1'b0;
					o_q[g] <= 1'b0;
				end else begin
					meta <= next_meta;
					o_q[g] <= next_q;
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ---- rri_stack_mem.sv ----
`timescale 1ns/10ps
`default_nettype none

module rri_stack_mem (
	// clock
	input wire logic i_clk,
	// write port
	input wire logic i_we,
	input wire logic [rri_pkg::STK_AW-1:0] i_waddr,
	input wire logic [rri_pkg::PC_W-1:0] i_wdata,
	// registered read port
	input wire logic [rri_pkg::STK_AW-1:0] i_raddr,
	output logic [rri_pkg::PC_W-1:0] o_rdata
);
	import rri_pkg::*;

	logic [PC_W-1:0] mem [STK_DEPTH];

	always_ff @(posedge i_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		o_rdata <= mem[i_raddr];
	end

endmodule

`default_nettype wire

// ---- rri_register_reset_init.sv ----
// Summary of operation
// - interrupt wake with matching global enable loads vector 0008h or 0018h
// - same wake pushes current pc onto stack top and advances pointer, or sets the full flag when the pointer is at 1Fh
// - every interrupt wake sets at least one cause flag in interrupt flag registers; watchdog wake sets none
// - port a bit 6 lives only in the two io oscillator modes, else zero
// - long write enable cleared only by power-on or external pin reset, or by a software write
// - unimplemented bits always read zero
// - per class, bits keep value, power up anyhow, or take the constant
// - reset status bits take values set by the specific event
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/10ps
`default_nettype none

module rri_register_reset_init (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// apb slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// reset sources from outside the clock domain
	input wire logic i_power_on_reset,
	input wire logic i_brown_out_reset,
	input wire logic i_external_reset_pin_n,
	// reset and wake events from core logic
	input wire rri_pkg::rri_core_evt_s i_core_evt,
	input wire logic i_sleeping,
	input wire rri_pkg::rri_wake_s i_wake,
	input wire logic [rri_pkg::PC_W-1:0] i_pc,
	// oscillator mode and port a
	input wire logic [2:0] i_osc_mode,
	input wire logic [7:0] i_port_a_pins,
	// to core
	output rri_pkg::rri_rsc_s o_reset_status_control,
	output logic [rri_pkg::PC_W-1:0] o_pc,
	output logic o_pc_load,
	output logic o_core_hold,
	output logic o_wake,
	output logic [7:0] o_port_a_latch,
	output logic [7:0] o_port_a_direction
);
	import rri_pkg::*;

	rri_state_e state, next_state;
	rri_class_e cls, next_cls;
	rri_class_e app_cls;
	rri_rsc_s rsc, next_rsc;
	rri_sptr_s sptr, next_sptr;
	logic [7:0] intcon, next_intcon;
	logic [7:0] pir1, next_pir1;
	logic [7:0] pa_lat, next_pa_lat;
	logic [7:0] pa_dir, next_pa_dir;
	logic [PC_W-1:0] pc, next_pc;
	logic pc_load, next_pc_load;
	logic wake, next_wake;
	logic [31:0] prdata, next_prdata;
	logic pslverr, next_pslverr;
	logic [SYNC_W-1:0] sync_q;
	logic por_s, bor_s, pin_n_s;
	logic [7:0] pins_s;
	logic ext_active, do_reset, do_wake, go_vec, wr_en, rd_setup;
	logic [15:0] rule;
	logic [7:0] pa_mask;
	logic [7:0] addr;
	logic [7:0] wbyte;
	logic mem_we;
	logic [STK_AW-1:0] mem_waddr;
	logic [PC_W-1:0] mem_wdata;
	logic [PC_W-1:0] tos;

	rri_sync u_sync (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.i_d({i_port_a_pins, i_external_reset_pin_n, i_brown_out_reset,
			i_power_on_reset}),
		.o_q(sync_q)
	);

	rri_stack_mem u_stack (
		.i_clk(i_clk),
		.i_we(mem_we),
		.i_waddr(mem_waddr),
		.i_wdata(mem_wdata),
		.i_raddr(sptr.ptr),
		.o_rdata(tos)
	);

	assign por_s = sync_q[0];
	assign bor_s = sync_q[1];
	assign pin_n_s = sync_q[2];
	assign pins_s = sync_q[10:3];
	assign ext_active = por_s | bor_s | ~pin_n_s;
	assign addr = i_paddr[7:0];
	assign wbyte = i_pwdata[7:0];
	assign wr_en = i_psel & i_penable & i_pwrite;
	assign rd_setup = i_psel & ~i_penable;

	// bit 6 of port a follows the oscillator mode
	assign pa_mask = (i_osc_mode == OSC_EXT_CLOCK_IO ||
		i_osc_mode == OSC_RC_IO) ? PA_MASK_FULL : PA_MASK_GATED;

	// keep mask and forced value of the reset status register per class
	function automatic logic [15:0] rsc_rule(input rri_class_e c);
		unique case (c)
			CLS_POR: rsc_rule = {RSC_POR_KEEP, RSC_POR_VAL};
			CLS_BOR: rsc_rule = {RSC_BOR_KEEP, RSC_BOR_VAL};
			CLS_PIN: rsc_rule = {RSC_PIN_KEEP, RSC_ZERO};
			CLS_PIN_SLEEP: rsc_rule = {RSC_PIN_SLP_KEEP, RSC_PIN_SLP_VAL};
			CLS_WDT: rsc_rule = {RSC_WDT_KEEP, RSC_WDT_VAL};
			CLS_INSTR: rsc_rule = {RSC_INSTR_KEEP, RSC_ZERO};
			CLS_STK_FULL: rsc_rule = {RSC_STK_KEEP, RSC_ZERO};
			CLS_STK_UNF: rsc_rule = {RSC_STK_KEEP, RSC_ZERO};
			CLS_WDT_WAKE: rsc_rule = {RSC_WAKE_KEEP, RSC_WDT_WAKE_VAL};
			CLS_INT_WAKE: rsc_rule = {RSC_WAKE_KEEP, RSC_INT_WAKE_VAL};
		endcase
	endfunction

	// sequencing and register updates
	always_comb begin
		next_state = state;
		next_cls = cls;
		next_rsc = rsc;
		next_sptr = sptr;
		next_intcon = intcon;
		next_pir1 = pir1;
		next_pa_lat = pa_lat;
		next_pa_dir = pa_dir;
		next_pc = pc;
		next_pc_load = 1'b0;
		next_wake = 1'b0;
		do_reset = 1'b0;
		do_wake = 1'b0;
		go_vec = 1'b0;
		app_cls = cls;
		mem_we = 1'b0;
		mem_waddr = STK_PTR_EMPTY;
		mem_wdata = PC_RESET;
		rule = 16'h0000;
		// software writes; hardware events below take precedence
		if (wr_en) begin
			case (addr)
				REG_RSC: next_rsc = (rsc & ~RSC_WMASK) | (wbyte & RSC_WMASK);
				REG_SPTR: next_sptr = wbyte;
				REG_INTCON: next_intcon = wbyte;
				REG_PIR1: next_pir1 = wbyte;
				REG_PA_LAT: next_pa_lat = wbyte;
				REG_PA_DIR: next_pa_dir = wbyte;
				default: next_pc_load = 1'b0;
			endcase
		end
		unique case (state)
			ST_RUN: begin
				if (ext_active) begin
					next_state = ST_HOLD;
					if (por_s) begin
						next_cls = CLS_POR;
					end else if (bor_s) begin
						next_cls = CLS_BOR;
					end else if (i_sleeping) begin
						next_cls = CLS_PIN_SLEEP;
					end else begin
						next_cls = CLS_PIN;
					end
				end else if (i_sleeping) begin
					if (i_core_evt.wdt_timeout) begin
						do_wake = 1'b1;
						app_cls = CLS_WDT_WAKE;
					end else if (|{i_wake.intcon_flags, i_wake.pir_flags}) begin
						do_wake = 1'b1;
						app_cls = CLS_INT_WAKE;
					end
				end else if (i_core_evt.wdt_timeout) begin
					next_state = ST_INIT;
					next_cls = CLS_WDT;
				end else if (i_core_evt.stack_full) begin
					next_state = ST_INIT;
					next_cls = CLS_STK_FULL;
				end else if (i_core_evt.stack_underflow) begin
					next_state = ST_INIT;
					next_cls = CLS_STK_UNF;
				end else if (i_core_evt.reset_instr) begin
					next_state = ST_INIT;
					next_cls = CLS_INSTR;
				end
			end
			ST_HOLD: begin
				if (por_s) begin
					next_cls = CLS_POR;
				end else if (bor_s && cls != CLS_POR) begin
					next_cls = CLS_BOR;
				end
				if (!ext_active) begin
					next_state = ST_INIT;
				end
			end
			ST_INIT: begin
				do_reset = 1'b1;
				next_state = ST_RUN;
			end
		endcase
		if (do_reset) begin
			rule = rsc_rule(cls);
			// keep bits stay, others take the class constant
			next_rsc = (rsc & rule[15:8]) | rule[7:0];
			next_sptr = SPTR_RST;
			next_sptr.full = (cls == CLS_STK_FULL);
			next_sptr.underflow = (cls == CLS_STK_UNF);
			if (cls == CLS_POR || cls == CLS_BOR) begin
				next_intcon = INTCON_RST;
				next_pa_lat = PA_LAT_POR;
			end else begin
				next_intcon = (intcon & INTCON_RST_KEEP) | INTCON_RST;
			end
			next_pir1 = PIR1_RST;
			next_pa_dir = PA_DIR_RST;
			next_pc = PC_RESET;
			next_pc_load = 1'b1;
			mem_we = 1'b1;
			mem_waddr = STK_PTR_EMPTY;
			mem_wdata = PC_RESET;
		end
		if (do_wake) begin
			rule = rsc_rule(app_cls);
			next_rsc = (next_rsc & rule[15:8]) | rule[7:0];
			next_wake = 1'b1;
			next_pc_load = 1'b1;
			next_pc = i_pc + PC_STEP;
			if (app_cls == CLS_INT_WAKE) begin
				// cause flags are set together with the wake, set over clear
				next_intcon = next_intcon | {5'b00000, i_wake.intcon_flags};
				next_pir1 = next_pir1 | i_wake.pir_flags;
				go_vec = i_wake.high_prio ? intcon[7] : intcon[6];
			end
			if (go_vec) begin
				next_pc = i_wake.high_prio ? VEC_HIGH : VEC_LOW;
				if (sptr.ptr == STK_PTR_MAX) begin
					next_sptr.full = 1'b1;
				end else begin
					next_sptr.ptr = sptr.ptr + 5'h01;
					mem_we = 1'b1;
					mem_waddr = sptr.ptr + 5'h01;
					mem_wdata = i_pc;
				end
			end
		end
		next_rsc = next_rsc & RSC_IMPL;
		next_sptr = next_sptr & SPTR_IMPL;
		next_pa_lat = next_pa_lat & pa_mask;
		next_pa_dir = next_pa_dir & pa_mask;
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			state <= ST_HOLD;
			cls <= CLS_POR;
			rsc <= RSC_POR_VAL;
			sptr <= SPTR_RST;
			intcon <= INTCON_RST;
			pir1 <= PIR1_RST;
			pa_lat <= PA_LAT_POR;
			pa_dir <= PA_MASK_GATED;
			pc <= PC_RESET;
			pc_load <= 1'b0;
			wake <= 1'b0;
		end else begin
			state <= next_state;
			cls <= next_cls;
			rsc <= next_rsc;
			sptr <= next_sptr;
			intcon <= next_intcon;
			pir1 <= next_pir1;
			pa_lat <= next_pa_lat;
			pa_dir <= next_pa_dir;
			pc <= next_pc;
			pc_load <= next_pc_load;
			wake <= next_wake;
		end
	end

	// apb read data captured in the setup phase
	always_comb begin
		next_prdata = prdata;
		next_pslverr = pslverr;
		if (rd_setup) begin
			next_pslverr = 1'b0;
			next_prdata = 32'h0000_0000;
			case (addr)
				REG_RSC: next_prdata = {24'h00_0000, rsc & RSC_IMPL};
				REG_SPTR: next_prdata = {24'h00_0000, sptr & SPTR_IMPL};
				REG_TOS: next_prdata = {11'h000, tos};
				REG_PC: next_prdata = {11'h000, pc};
				REG_INTCON: next_prdata = {24'h00_0000, intcon};
				REG_PIR1: next_prdata = {24'h00_0000, pir1};
				REG_PA_LAT: next_prdata = {24'h00_0000, pa_lat & pa_mask};
				REG_PA_DIR: next_prdata = {24'h00_0000, pa_dir & pa_mask};
				REG_PA_PINS: next_prdata = {24'h00_0000, pins_s & pa_mask};
				default: next_pslverr = 1'b1;
			endcase
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_rst) begin
			prdata <= 32'h0000_0000;
			pslverr <= 1'b0;
		end else begin
			prdata <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	assign o_prdata = prdata;
	assign o_pslverr = pslverr;
	assign o_pready = 1'b1;
	assign o_reset_status_control = rsc;
	assign o_pc = pc;
	assign o_pc_load = pc_load;
	assign o_core_hold = (state != ST_RUN);
	assign o_wake = wake;
	assign o_port_a_latch = pa_lat;
	assign o_port_a_direction = pa_dir;

endmodule

`default_nettype wire

// ---- rri_register_reset_init_sva.sv ----
`timescale 1ns/10ps
`default_nettype none
module rri_register_reset_init_sva (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst,
	// bus and reset inputs
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [31:0] i_paddr,
	input wire logic i_power_on_reset,
	input wire logic i_external_reset_pin_n,
	// core side inputs
	input wire rri_pkg::rri_core_evt_s i_core_evt,
	input wire logic i_sleeping,
	input wire rri_pkg::rri_wake_s i_wake,
	input wire logic [rri_pkg::PC_W-1:0] i_pc,
	input wire logic [2:0] i_osc_mode,
	// watched outputs
	input wire rri_pkg::rri_rsc_s o_reset_status_control,
	input wire logic [rri_pkg::PC_W-1:0] o_pc,
	input wire logic o_pc_load,
	input wire logic o_core_hold,
	input wire logic o_wake,
	input wire logic [7:0] o_port_a_latch,
	input wire logic [7:0] o_port_a_direction
);
	import rri_pkg::*;
	logic [3:0] lvl_cnt;
	logic sw_wr_q, cause_q, free_q1, free_q2, free_now;
	logic [PC_W-1:0] pc_q;
	assign free_now = i_osc_mode == OSC_EXT_CLOCK_IO || i_osc_mode == OSC_RC_IO;
	always_ff @(posedge i_clk) begin
		if (i_rst || i_power_on_reset || !i_external_reset_pin_n) begin
			lvl_cnt <= 4'h0;
		end else if (lvl_cnt != 4'hF) begin
			lvl_cnt <= lvl_cnt + 4'h1;
		end
		sw_wr_q <= i_psel && i_penable && i_pwrite && i_paddr[7:0] == REG_RSC;
		cause_q <= i_sleeping && (i_core_evt.wdt_timeout
			|| |{i_wake.intcon_flags, i_wake.pir_flags});
		free_q1 <= free_now;
		free_q2 <= free_q1;
		pc_q <= i_pc;
	end
	default clocking dc @(posedge i_clk); endclocking
	default disable iff (i_rst);
	wake_vector_a: assert property (
		o_wake |-> o_pc == VEC_HIGH || o_pc == VEC_LOW || o_pc == pc_q + PC_STEP)
		else $error("wake pc is no vector and no step");
	wake_load_a: assert property (o_wake |-> o_pc_load)
		else $error("wake without pc load");
	wake_cause_a: assert property (o_wake |-> cause_q)
		else $error("wake without a cause");
	pin_gate_a: assert property (
		!free_now && !free_q1 && !free_q2
		|-> !o_port_a_latch[6] && !o_port_a_direction[6])
		else $error("port bit 6 live in gated mode");
	unused_zero_a: assert property (
		!o_port_a_latch[7] && !o_port_a_direction[7]
		&& !o_reset_status_control.rsvd)
		else $error("unimplemented bit set");
	lwe_clear_a: assert property (
		$fell(o_reset_status_control.long_write_en) |-> lvl_cnt < 4'h8 || sw_wr_q)
		else $error("long write cleared by other source");
	wake_sleep_a: assert property (
		o_wake |-> ##[0:1] !o_reset_status_control.power_down_n)
		else $error("power down flag not set on wake");
	reset_pc_a: assert property (o_pc_load && !o_wake |-> o_pc == PC_RESET)
		else $error("reset load with nonzero pc");
	pin_hold_a: assert property (
		!i_external_reset_pin_n |-> ##[2:4] o_core_hold)
		else $error("core not held during pin reset");
endmodule
bind rri_register_reset_init rri_register_reset_init_sva chk_u (
	.i_clk(i_clk), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
	.i_pwrite(i_pwrite), .i_paddr(i_paddr),
	.i_power_on_reset(i_power_on_reset),
	.i_external_reset_pin_n(i_external_reset_pin_n),
	.i_core_evt(i_core_evt), .i_sleeping(i_sleeping), .i_wake(i_wake),
	.i_pc(i_pc), .i_osc_mode(i_osc_mode),
	.o_reset_status_control(o_reset_status_control), .o_pc(o_pc),
	.o_pc_load(o_pc_load), .o_core_hold(o_core_hold), .o_wake(o_wake),
	.o_port_a_latch(o_port_a_latch), .o_port_a_direction(o_port_a_direction)
);
`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) chk(32'(g), 32'(e))
module tb_top;
	import rri_pkg::*;
	logic i_clk, i_rst, psel, pen, pwr, por, bor, pin_n, slp, pld, hold;
	logic wake, prdy, perr, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [PC_W-1:0] pc, pc_o, pcv, pe;
	logic [7:0] pins, lat, dir, st, f, m;
	logic [2:0] osc;
	rri_core_evt_s evt;
	rri_wake_s wk;
	rri_rsc_s rs;
	int num_errors, total_checks, i, n, sp;
	rri_register_reset_init dut_u (
		.i_clk(i_clk), .i_rst(i_rst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
		.o_prdata(prdata), .o_pready(prdy), .o_pslverr(perr),
		.i_power_on_reset(por), .i_brown_out_reset(bor),
		.i_external_reset_pin_n(pin_n), .i_core_evt(evt),
		.i_sleeping(slp), .i_wake(wk), .i_pc(pc), .i_osc_mode(osc),
		.i_port_a_pins(pins), .o_reset_status_control(rs), .o_pc(pc_o),
		.o_pc_load(pld), .o_core_hold(hold), .o_wake(wake),
		.o_port_a_latch(lat), .o_port_a_direction(dir)
	);
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask
	task automatic conclude();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= w;
		paddr <= {24'h00_0000, a};
		pwdata <= {24'h00_0000, d};
		@(posedge i_clk);
		pen <= 1'b1;
		n = 0;
		do begin
			@(posedge i_clk);
			n++;
		end while (prdy !== 1'b1 && n < 20);
		rd = prdata;
		err = perr;
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge i_clk);
		if (n == 20) begin
			num_errors++;
			conclude();
		end
	endtask
	task automatic wait_run();
		n = 0;
		#1;
		while (hold !== 1'b0 && n < 40) begin
			@(posedge i_clk);
			#1;
			n++;
		end
		@(posedge i_clk);
		if (n == 40) begin
			num_errors++;
			conclude();
		end
	endtask
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	initial begin
		{i_rst, psel, pen, pwr, por, bor, pin_n, slp} = 8'h82;
		{paddr, pwdata, pc, osc, pins, evt, wk} = '0;
		void'($urandom(32'h8e21));
		repeat (6) @(posedge i_clk);
		i_rst <= 1'b0;
		wait_run();
		st = 8'h1C;
		apb(0, REG_RSC, 0);
		`CHK(rd, st);
		`CHK(dir, 8'h3F);
		`CHK(lat, 8'h00);
		$display("power-up test done");
		for (i = 0; i < 8; i++) begin
			osc <= 3'(i);
			pins <= 8'($urandom);
			apb(1, REG_PA_LAT, 8'hFF);
			apb(1, REG_PA_DIR, 8'hFF);
			m = (i == 5 || i == 7) ? 8'h7F : 8'h3F;
			apb(0, REG_PA_PINS, 0);
			`CHK(rd[6], pins[6] & m[6]);
			apb(0, REG_PA_LAT, 0);
			`CHK(rd, m);
			`CHK(lat, m);
			`CHK(dir, m);
		end
		$display("oscillator mode test done");
		sp = 0;
		for (i = 0; i < 4; i++) begin
			apb(1, REG_INTCON, i == 1 ? 8'h40 : (i == 2 ? 8'h80 : 8'h00));
			pcv = 21'($urandom) & 21'h1F_FFFE;
			f = 8'($urandom) | 8'h01;
			pe = i == 1 ? 21'h0_0018 : (i == 2 ? 21'h0_0008 : pcv + 21'h0_0002);
			slp <= 1'b1;
			pc <= pcv;
			wk <= (i == 3) ? 12'h000 : {i == 2, 3'h0, f};
			evt <= (i == 3) ? 4'h8 : 4'h0;
			@(posedge i_clk);
			wk <= 12'h000;
			evt <= 4'h0;
			slp <= 1'b0;
			#1;
			`CHK(wake, 1'b1);
			`CHK(pc_o, pe);
			@(posedge i_clk);
			sp += (i == 1 || i == 2);
			apb(0, REG_SPTR, 0);
			`CHK(rd, sp);
			apb(0, REG_TOS, 0);
			if (i == 1 || i == 2) `CHK(rd, pcv);
			apb(0, REG_PIR1, 0);
			if (i != 3) `CHK(rd, f);
			apb(1, REG_PIR1, 0);
			st = {st[7:4], i != 3, 1'b0, st[1:0]};
			apb(0, REG_RSC, 0);
			`CHK(rd, st);
		end
		$display("wake test done");
		for (i = 0; i < 7; i++) begin
			apb(1, REG_RSC, 8'hFF);
			st = (st & 8'h2C) | 8'hD3;
			apb(1, REG_PA_LAT, 8'hEA);
			apb(1, REG_INTCON, 8'h01);
			apb(1, REG_PA_DIR, 8'h05);
			evt <= (i >= 1 && i <= 4) ? 4'h8 >> (i - 1) : 4'h0;
			bor <= i == 0;
			pin_n <= i != 5;
			por <= i == 6;
			@(posedge i_clk);
			evt <= 4'h0;
			repeat (3) @(posedge i_clk);
			{bor, pin_n, por} <= 3'b010;
			@(posedge i_clk);
			wait_run();
			case (i)
				0: st = {1'b0, st[6], 4'b0111, st[1], 1'b0};
				1: st = {1'b0, st[6], 1'b0, st[4], 2'b01, st[1:0]};
				2: st = {1'b0, st[6], 2'b00, st[3:0]};
				3, 4: st = {1'b0, st[6], 1'b0, st[4:0]};
				5: st = {3'b000, st[4:0]};
				default: st = 8'h1C;
			endcase
			apb(0, REG_RSC, 0);
			`CHK(rd, st);
			`CHK(rs, st);
			apb(0, REG_PA_LAT, 0);
			`CHK(rd, (i == 0 || i == 6) ? 8'h00 : 8'h6A);
			apb(0, REG_PA_DIR, 0);
			`CHK(rd, 8'h7F);
			apb(0, REG_INTCON, 0);
			if (i != 0) `CHK(rd, i == 6 ? 8'h00 : 8'h01);
			apb(0, REG_SPTR, 0);
			`CHK(rd[4:0], 5'h00);
			$display("reset event %0d test done", i);
		end
		apb(0, 8'h40, 0);
		`CHK(rd, 0);
		`CHK(err, 1'b1);
		$display("unmapped test done");
		conclude();
	end
endmodule
`default_nettype wire
